// ===== hw/crs_readout.sv
// Status flags, ready pin and result registers of the converter readout.
// Assumes the serial front end gives pointer loads, byte reads and stop.
//
// Overview of operation
// R1: Status bits seven to three always read as zero.
// R2: Combined flag low when enabled channels finished and unread data exists.
// R3: With both channels on, combined flag falls only after both finish.
// R4: Combined flag returns high on data read or before next conversion ends.
// R5: With one channel on, combined flag follows that channel's flag.
// R6: Voltage/temperature flag low after its conversion until result is read.
// R7: Capacitive flag low after its conversion until result is read.
// R8: Active-low ready pin mirrors the combined completion flag.
// R9: Capacitive result loads, but is dropped while its read is in progress.
// R10: Bus stop ends a result read and releases the update lock.
// R11: Master should read all three result bytes in one transfer.
// R12: Master should read capacitive result before the next one finishes.
// R13: Capacitive results are offset binary, mid code meaning zero.
// R14: Voltage/temperature result loads, dropped while its read is in progress.
// R15: Voltage results are offset binary, mid code meaning zero volts.
// R16: Temperature code gives degrees as code over 2048 minus 4096.
// R17: Master should read voltage/temperature result before the next one.
// R18: Status resets to 0x07, results reset to zero.
// R19: Pointer advances after each transferred byte until a stop.
// R20: Capacitive enable decides its part in the combined flag.
`timescale 1ns/1ps
`default_nettype none
module crs_readout
  import crs_pkg::*;
#(
  parameter int RES_W = CRS_RES_W
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  capacitive_channel_on,
  input  wire logic                  volt_temp_channel_on,
  input  wire logic                  cap_result_valid,
  input  wire logic [RES_W-1:0]      cap_result,
  input  wire logic                  vt_result_valid,
  input  wire logic [RES_W-1:0]      vt_result,
  input  wire logic                  conversion_start,
  input  wire logic                  ptr_load,
  input  wire logic [CRS_PTR_W-1:0]  ptr_value,
  input  wire logic                  byte_read,
  input  wire logic                  bus_stop,
  output var  logic [CRS_BYTE_W-1:0] read_data,
  output var  logic [CRS_PTR_W-1:0]  reg_pointer,
  output var  logic [CRS_BYTE_W-1:0] conversion_status,
  output var  logic [RES_W-1:0]      capacitance_result,
  output var  logic [RES_W-1:0]      voltage_temperature_result,
  output logic                       ready_n
);
  crs_bus_state_t   bus_state;
  crs_bus_state_t   next_bus_state;
  logic [CRS_PTR_W-1:0]  next_reg_pointer;
  logic [CRS_BYTE_W-1:0] next_read_data;
  logic             cap_lock;
  logic             vt_lock;
  logic             next_cap_lock;
  logic             next_vt_lock;
  logic             capacitance_done_n;
  logic             volt_temp_done_n;
  logic             all_done_n;
  logic             next_cap_done_n;
  logic             next_vt_done_n;
  logic             next_all_done_n;
  logic             cap_taken;
  logic             vt_taken;
  logic             cap_pending;
  logic             vt_pending;
  logic             next_cap_pending;
  logic             next_vt_pending;
  logic             rd_cap;
  logic             rd_vt;

  function automatic logic is_cap(input logic [CRS_PTR_W-1:0] a);
    return (a >= CRS_ADDR_CAP_H) && (a <= CRS_ADDR_CAP_L);
  endfunction

  function automatic logic is_vt(input logic [CRS_PTR_W-1:0] a);
    return (a >= CRS_ADDR_VT_H) && (a <= CRS_ADDR_VT_L);
  endfunction

  // R9 capacitive result hold; R13 offset binary passes unchanged
  crs_result_hold #(.WIDTH(RES_W)) u_cap_hold (
    .clk       (clk),
    .reset     (reset),
    .load      (cap_result_valid),
    .locked    (cap_lock || rd_cap),
    .load_data (cap_result),
    .data      (capacitance_result),
    .taken     (cap_taken)
  );

  // R14 voltage/temperature hold; R15 R16 codes pass unchanged
  crs_result_hold #(.WIDTH(RES_W)) u_vt_hold (
    .clk       (clk),
    .reset     (reset),
    .load      (vt_result_valid),
    .locked    (vt_lock || rd_vt),
    .load_data (vt_result),
    .data      (voltage_temperature_result),
    .taken     (vt_taken)
  );

  assign rd_cap = byte_read && is_cap(reg_pointer);
  assign rd_vt  = byte_read && is_vt(reg_pointer);

  // Bus read tracking and pointer
  always_comb begin
    next_bus_state   = bus_state;
    next_reg_pointer = reg_pointer;
    next_read_data   = read_data;
    next_cap_lock    = cap_lock;
    next_vt_lock     = vt_lock;
    if (ptr_load) begin
      next_reg_pointer = ptr_value;
    end
    if (byte_read) begin
      next_bus_state = CRS_BUS_READ;
      case (reg_pointer)
        // R1 upper status bits zero
        CRS_ADDR_STATUS: next_read_data = conversion_status;
        CRS_ADDR_CAP_H:  next_read_data = capacitance_result[23:16];
        CRS_ADDR_CAP_M:  next_read_data = capacitance_result[15:8];
        CRS_ADDR_CAP_L:  next_read_data = capacitance_result[7:0];
        CRS_ADDR_VT_H:   next_read_data = voltage_temperature_result[23:16];
        CRS_ADDR_VT_M:   next_read_data = voltage_temperature_result[15:8];
        CRS_ADDR_VT_L:   next_read_data = voltage_temperature_result[7:0];
        default:         next_read_data = 8'h00;
      endcase
      // R19 pointer auto-increment
      next_reg_pointer = reg_pointer + 8'h01;
      // R9 lock during read
      if (rd_cap) begin
        next_cap_lock = 1'b1;
      end
      // R14 lock during read
      if (rd_vt) begin
        next_vt_lock = 1'b1;
      end
    end
    // R10 stop releases locks
    if (bus_stop) begin
      next_bus_state = CRS_BUS_IDLE;
      next_cap_lock  = 1'b0;
      next_vt_lock   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_state   <= CRS_BUS_IDLE;
      reg_pointer <= CRS_ADDR_STATUS;
      read_data   <= 8'h00;
      cap_lock    <= 1'b0;
      vt_lock     <= 1'b0;
    end else begin
      bus_state   <= next_bus_state;
      reg_pointer <= next_reg_pointer;
      read_data   <= next_read_data;
      cap_lock    <= next_cap_lock;
      vt_lock     <= next_vt_lock;
    end
  end

  // Completion flags
  always_comb begin
    next_cap_done_n  = capacitance_done_n;
    next_vt_done_n   = volt_temp_done_n;
    next_all_done_n  = all_done_n;
    next_cap_pending = cap_pending;
    next_vt_pending  = vt_pending;
    // R4 flag high at new conversion
    if (conversion_start) begin
      next_all_done_n  = 1'b1;
      next_cap_pending = 1'b0;
      next_vt_pending  = 1'b0;
    end
    // R7 read clears capacitive flag
    if (rd_cap) begin
      next_cap_done_n = 1'b1;
    end
    // R6 read clears voltage flag
    if (rd_vt) begin
      next_vt_done_n = 1'b1;
    end
    // R4 R5 read of enabled channel
    if ((rd_cap && capacitive_channel_on) || (rd_vt && volt_temp_channel_on)) begin
      next_all_done_n = 1'b1;
    end
    // R7 capacitive finished, set wins
    if (cap_taken) begin
      next_cap_done_n  = 1'b0;
      next_cap_pending = 1'b1;
    end
    // R6 voltage finished, set wins
    if (vt_taken) begin
      next_vt_done_n  = 1'b0;
      next_vt_pending = 1'b1;
    end
    // R20 R3 R5 combine enabled channels
    if ((cap_taken || vt_taken)
        && (!capacitive_channel_on || next_cap_pending)
        && (!volt_temp_channel_on || next_vt_pending)
        && (capacitive_channel_on || volt_temp_channel_on)) begin
      // R2 combined flag low
      next_all_done_n  = 1'b0;
      next_cap_pending = 1'b0;
      next_vt_pending  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // R18 reset values
      capacitance_done_n <= CRS_STATUS_RESET[CRS_BIT_CAP];
      volt_temp_done_n   <= CRS_STATUS_RESET[CRS_BIT_VT];
      all_done_n         <= CRS_STATUS_RESET[CRS_BIT_ALL];
      cap_pending        <= 1'b0;
      vt_pending         <= 1'b0;
    end else begin
      capacitance_done_n <= next_cap_done_n;
      volt_temp_done_n   <= next_vt_done_n;
      all_done_n         <= next_all_done_n;
      cap_pending        <= next_cap_pending;
      vt_pending         <= next_vt_pending;
    end
  end

  // R1 status assembly
  assign conversion_status = {5'h00, all_done_n, volt_temp_done_n, capacitance_done_n};

  // R8 ready pin mirrors flag
  assign ready_n = all_done_n;
endmodule
`default_nettype wire

// ===== common/crs_pkg.sv
// Package for the conversion status and result readout block.
// Assumes a byte-wide register port fed by a serial bus front end.
package crs_pkg;
  localparam int            CRS_PTR_W        = 8;
  localparam int            CRS_RES_W        = 24;
  localparam int            CRS_BYTE_W       = 8;
  localparam logic [7:0]    CRS_ADDR_STATUS  = 8'h00;
  localparam logic [7:0]    CRS_ADDR_CAP_H   = 8'h01;
  localparam logic [7:0]    CRS_ADDR_CAP_M   = 8'h02;
  localparam logic [7:0]    CRS_ADDR_CAP_L   = 8'h03;
  localparam logic [7:0]    CRS_ADDR_VT_H    = 8'h04;
  localparam logic [7:0]    CRS_ADDR_VT_M    = 8'h05;
  localparam logic [7:0]    CRS_ADDR_VT_L    = 8'h06;
  localparam logic [7:0]    CRS_STATUS_RESET = 8'h07;
  localparam logic [23:0]   CRS_RESULT_RESET = 24'h000000;
  localparam logic [23:0]   CRS_CAP_ZERO     = 24'h800000;
  localparam int            CRS_BIT_CAP      = 0;
  localparam int            CRS_BIT_VT       = 1;
  localparam int            CRS_BIT_ALL      = 2;
  localparam int            CRS_TEMP_DIV     = 2048;
  localparam int            CRS_TEMP_OFFSET  = 4096;
  typedef enum logic [1:0] {
    CRS_BUS_IDLE = 2'b01,
    CRS_BUS_READ = 2'b10
  } crs_bus_state_t;
endpackage

// ===== hw/crs_result_hold.sv
// Holding register for one 24-bit conversion result.
// Assumes load and lock come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module crs_result_hold
  import crs_pkg::*;
#(
  parameter int WIDTH = CRS_RES_W
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic             locked,
  input  wire logic [WIDTH-1:0] load_data,
  output var  logic [WIDTH-1:0] data,
  output logic                  taken
);
  logic [WIDTH-1:0] next_data;

  // Load skipped while locked
  always_comb begin
    next_data = data;
    if (load && !locked) begin
      next_data = load_data;
    end
  end

  assign taken = load && !locked;

  always_ff @(posedge clk) begin
    if (reset) begin
      data <= WIDTH'(CRS_RESULT_RESET);
    end else begin
      data <= next_data;
    end
  end
endmodule
`default_nettype wire

// ===== verif/crs_master_model.sv
// Byte-level bus master model that reads the readout registers.
// Assumes the design samples requests on the rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module crs_master_model (
  input  wire logic       clk,
  input  wire logic [7:0] read_data,
  output var  logic       ptr_load,
  output var  logic [7:0] ptr_value,
  output var  logic       byte_read,
  output var  logic       bus_stop
);
  initial {ptr_load, ptr_value, byte_read, bus_stop} = '0;
  task automatic rd(input logic [7:0] a, input int n, output logic [23:0] v);
    v = '0;
    @(posedge clk);
    ptr_load  <= 1'b1;
    ptr_value <= a;
    @(posedge clk);
    ptr_load  <= 1'b0;
    ptr_value <= ~a;
    byte_read <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i == n - 1) begin
        byte_read <= 1'b0;
      end
      #1;
      v = {v[15:0], read_data};
    end
    @(posedge clk);
    bus_stop <= 1'b1;
    @(posedge clk);
    bus_stop <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verif/crs_readout_chk.sv
// Port checker of the readout block.
// Assumes it is bound onto every crs_readout instance.
`timescale 1ns/1ps
`default_nettype none
module crs_readout_chk
  import crs_pkg::*;
#(
  parameter int RES_W = CRS_RES_W
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             capacitive_channel_on,
  input wire logic             cap_result_valid,
  input wire logic [RES_W-1:0] cap_result,
  input wire logic             vt_result_valid,
  input wire logic             conversion_start,
  input wire logic             byte_read,
  input wire logic             bus_stop,
  input wire logic [7:0]       read_data,
  input wire logic [7:0]       reg_pointer,
  input wire logic [7:0]       conversion_status,
  input wire logic [RES_W-1:0] capacitance_result,
  input wire logic [RES_W-1:0] voltage_temperature_result,
  input wire logic             ready_n
);
  logic cap_busy;
  logic vt_busy;
  logic cap_rd_now;
  logic vt_rd_now;

  assign cap_rd_now = byte_read && (reg_pointer inside {[CRS_ADDR_CAP_H:CRS_ADDR_CAP_L]});
  assign vt_rd_now  = byte_read && (reg_pointer inside {[CRS_ADDR_VT_H:CRS_ADDR_VT_L]});
  always_ff @(posedge clk) begin
    if (reset || bus_stop) begin
      cap_busy <= 1'b0;
      vt_busy  <= 1'b0;
    end else begin
      cap_busy <= cap_busy || cap_rd_now;
      vt_busy  <= vt_busy || vt_rd_now;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_HI_ZERO: assert property (conversion_status[7:3] == 5'h00)
    else $error("status high bits set");
  AST_PIN: assert property (ready_n == conversion_status[2])
    else $error("ready pin differs");
  AST_CAP_SET: assert property ($changed(capacitance_result) |-> !conversion_status[0])
    else $error("cap flag not set");
  AST_VT_SET: assert property ($changed(voltage_temperature_result) |-> !conversion_status[1])
    else $error("vt flag not set");
  AST_CAP_LOAD: assert property (cap_result_valid && !cap_busy && !cap_rd_now |=>
    capacitance_result == $past(cap_result))
    else $error("cap result not loaded");
  AST_CAP_DROP: assert property (cap_result_valid && (cap_busy || cap_rd_now) |=>
    $stable(capacitance_result))
    else $error("cap result loaded during read");
  AST_VT_DROP: assert property (vt_result_valid && (vt_busy || vt_rd_now) |=>
    $stable(voltage_temperature_result))
    else $error("vt result loaded during read");
  AST_PTR_INC: assert property (byte_read |=> reg_pointer == $past(reg_pointer) + 8'h01)
    else $error("pointer not advanced");
  AST_CAP_CLR: assert property (byte_read && reg_pointer inside {[8'h01:8'h03]} &&
    !cap_result_valid && !vt_result_valid |=> conversion_status[0] &&
    (conversion_status[2] || !$past(capacitive_channel_on)))
    else $error("read did not clear flags");
  AST_STAT_READ: assert property (byte_read && reg_pointer == CRS_ADDR_STATUS |=>
    read_data == $past(conversion_status))
    else $error("status read wrong");
  AST_START: assert property (conversion_start && !cap_result_valid &&
    !vt_result_valid |=> conversion_status[2])
    else $error("start kept combined low");
  cover property (cap_result_valid);
  cover property (byte_read && reg_pointer == CRS_ADDR_VT_L);
  cover property ($fell(ready_n));
  cover property (cap_busy && cap_result_valid);
  cover property (vt_busy && vt_result_valid);
endmodule
bind crs_readout crs_readout_chk #(.RES_W(RES_W)) i_chk (.clk, .reset, .capacitive_channel_on,
  .cap_result_valid, .cap_result, .vt_result_valid, .conversion_start, .byte_read, .bus_stop,
  .read_data, .reg_pointer,
  .conversion_status, .capacitance_result, .voltage_temperature_result, .ready_n);
`default_nettype wire

// ===== verif/crs_readout_bench.sv
// Self-checking bench of the readout block with a bus master model.
// Assumes the package, design, checker and master model compile first.
`timescale 1ns/1ps
`default_nettype none
module crs_readout_bench
  import crs_pkg::*;
;
  logic        clk, reset, cap_on, vt_on, cap_v, vt_v, start, pl, br, bs, ready_n;
  logic [7:0]  pv, rd, ptr, st;
  logic [23:0] cr, vr, cres, vres, v, d;
  logic [31:0] seed = 32'h61c4;
  int          failures, compares;
  localparam logic [23:0] CORNER [3] = '{24'h000000, 24'h800000, 24'hffffff};
  crs_readout i_dut (.clk, .reset, .capacitive_channel_on(cap_on), .volt_temp_channel_on(vt_on),
    .cap_result_valid(cap_v), .cap_result(cr), .vt_result_valid(vt_v), .vt_result(vr),
    .conversion_start(start), .ptr_load(pl), .ptr_value(pv), .byte_read(br), .bus_stop(bs),
    .read_data(rd), .reg_pointer(ptr), .conversion_status(st), .capacitance_result(cres),
    .voltage_temperature_result(vres), .ready_n);
  crs_master_model i_mst (.clk, .read_data(rd), .ptr_load(pl), .ptr_value(pv),
    .byte_read(br), .bus_stop(bs));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic c, input logic t, input logic [23:0] x);
    @(posedge clk);
    cap_v <= c;
    vt_v  <= t;
    cr    <= x;
    vr    <= ~x;
    @(posedge clk);
    {cap_v, vt_v} <= 2'b00;
    cr <= ~x;
    vr <= x;
    #1;
  endtask
  task automatic final_report;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50us;
    failures++;
    final_report;
  end
  initial begin
    {reset, cap_on, vt_on, cap_v, vt_v, start} = 6'h20;
    {cr, vr} = '0;
    repeat (10) @(posedge clk);
    reset  <= 1'b0;
    cap_on <= 1'b1;
    vt_on  <= 1'b1;
    @(posedge clk);
    #1;
    chk(st, 8'h07);
    chk(cres | vres, 24'h000000);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      d = (k < 3) ? CORNER[k] : seed[23:0];
      conv(1'b1, 1'b0, d);
      chk(st, 8'h06);
      conv(1'b0, 1'b1, d);
      chk(st, 8'h00);
      i_mst.rd(CRS_ADDR_CAP_H, 3, v);
      chk(v, d);
      i_mst.rd(CRS_ADDR_VT_H, 3, v);
      chk(v, ~d);
      i_mst.rd(CRS_ADDR_STATUS, 1, v);
      chk(v, 24'h000007);
    end
    $display("test both channels done");
    vt_on <= 1'b0;
    conv(1'b1, 1'b0, d);
    chk(st, 8'h02);
    chk(ready_n, 1'b0);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk(ready_n, 1'b1);
    i_mst.rd(CRS_ADDR_CAP_H, 3, v);
    $display("test single channel done");
    seed = lfsr(seed);
    fork
      i_mst.rd(CRS_ADDR_CAP_H, 3, v);
      begin
        repeat (4) @(posedge clk);
        conv(1'b1, 1'b0, seed[23:0]);
      end
    join
    #1;
    chk(v, d);
    chk(cres, d);
    conv(1'b1, 1'b0, seed[23:0]);
    chk(cres, seed[23:0]);
    $display("test read lock done");
    seed = lfsr(seed);
    fork
      i_mst.rd(CRS_ADDR_VT_H, 3, v);
      begin
        repeat (4) @(posedge clk);
        conv(1'b0, 1'b1, seed[23:0]);
      end
    join
    #1;
    chk(v, ~d);
    chk(vres, ~d);
    chk(st, 8'h02);
    conv(1'b0, 1'b1, seed[23:0]);
    chk(vres, ~seed[23:0]);
    chk(st, 8'h00);
    d = seed[23:0];
    i_mst.rd(CRS_ADDR_CAP_H, 6, v);
    cap_on <= 1'b0;
    vt_on  <= 1'b1;
    seed = lfsr(seed);
    conv(1'b0, 1'b1, seed[23:0]);
    chk(v, ~d);
    chk(ptr, 8'h07);
    chk(st, 8'h01);
    i_mst.rd(CRS_ADDR_VT_H, 3, v);
    chk(v, ~seed[23:0]);
    i_mst.rd(CRS_ADDR_STATUS, 1, v);
    chk(v, 24'h000007);
    $display("test channel enable done");
    final_report;
  end
endmodule
`default_nettype wire
